//--- hdl/dfd_params.svh
// constants for the dual fractional divider control core
`ifndef DFD_PARAMS_SVH
`define DFD_PARAMS_SVH

`define DFD_NUM_REGS     10
`define DFD_ADDR_HI      15
`define DFD_ADDR_LO      12
`define DFD_A_MAIN_N     4'h0
`define DFD_A_AUX_N      4'h1
`define DFD_A_MAIN_MSB   4'h2
`define DFD_A_MAIN_LSB   4'h3
`define DFD_A_AUX_DVD    4'h4
`define DFD_A_REF_DIV    4'h5
`define DFD_A_PUMP       4'h6
`define DFD_A_PWRDN      4'h7
`define DFD_A_MODE       4'h8
`define DFD_A_MOD_DATA   4'h9
`define DFD_RST_VAL      16'h0000
`define DFD_SHORT_EDGES  5'h0D
`define DFD_WORD_EDGES   5'h10
`define DFD_N_OFFSET     12'h020
`define DFD_MODE_B18     0
`define DFD_MODE_MFRAC   1
`define DFD_MODE_AFRAC   2
`define DFD_MODE_LOCK    3
`define DFD_MODE_MUX_LO  4
`define DFD_M_FRAC_MIN   12'h098
`define DFD_M_FRAC_MAX   12'h864
`define DFD_M_INT_MIN    12'h080
`define DFD_M_INT_MAX    12'h87C
`define DFD_A_FRAC_MIN   12'h026
`define DFD_A_FRAC_MAX   12'h219
`define DFD_A_INT_MIN    12'h020
`define DFD_A_INT_MAX    12'h21F
`define DFD_ACC_HALF     21'h020000
`define DFD_ACC_FULL     21'h040000

`endif

//--- hdl/dfd_pkg.sv
// types shared by the dual fractional divider control core
package dfd_pkg;
  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT} dfd_ser_st_t;
  typedef enum logic [1:0] {MUX_LOOP, MUX_LOCK, MUX_REF_MAIN, MUX_REF_AUX} dfd_mux_t;
  typedef logic signed [18:0] dfd_dvd_t;
  typedef logic signed [1:0]  dfd_step_t;
endpackage

//--- hdl/dfd_frac_if.sv
// link between the control core and one fractional unit
`timescale 1ns/1ps
interface dfd_frac_if;
  import dfd_pkg::*;
  logic      tick;
  dfd_dvd_t  dividend;
  dfd_step_t step;
  modport unit (input tick, input dividend, output step);
  modport ctrl (output tick, output dividend, input step);
endinterface

//--- hdl/dfd_frac_unit.sv
// first-order delta-sigma fractional unit
`timescale 1ns/1ps
`include "dfd_params.svh"
module dfd_frac_unit
  import dfd_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  dfd_frac_if.unit  frac
);
  logic signed [20:0] acc_reg;
  logic signed [20:0] acc_next;
  logic signed [20:0] err_sum;
  dfd_step_t          step_reg;
  dfd_step_t          step_next;

  // ------------------------------------------------------------
  // error feedback quantiser
  // ------------------------------------------------------------
  // quantise to one step
  always_comb begin
    err_sum   = acc_reg + 21'(frac.dividend);
    acc_next  = err_sum;
    step_next = 2'sd0;
    if (err_sum >= $signed(`DFD_ACC_HALF)) begin
      acc_next  = err_sum - $signed(`DFD_ACC_FULL);
      step_next = 2'sd1;
    end else if (err_sum < -$signed(`DFD_ACC_HALF)) begin
      acc_next  = err_sum + $signed(`DFD_ACC_FULL);
      step_next = -2'sd1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_reg  <= 21'h000000;
      step_reg <= 2'sd0;
    end else if (frac.tick) begin
      acc_reg  <= acc_next;
      step_reg <= step_next;
    end
  end

  assign frac.step = step_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_acc_bound;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      frac.tick |=> (acc_reg >= -$signed(`DFD_ACC_HALF)) && (acc_reg < $signed(`DFD_ACC_HALF));
  endproperty
  a_acc_bound: assert property (p_acc_bound) else $error("accumulator left range");

  c_step_up: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) step_reg == 2'sd1);
endmodule

//--- hdl/dfd_ctrl.sv
// serial register core, reference dividers and ratio control
`timescale 1ns/1ps
`include "dfd_params.svh"
module dfd_ctrl
  import dfd_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_sclk,
  input  wire logic        i_sdata,
  input  wire logic        i_csn,
  input  wire logic        i_xtal,
  input  wire logic        i_main_locked,
  input  wire logic        i_vco_slow,
  input  wire logic        i_vco_fast,
  output logic             o_sdo,
  output logic             o_ref_main,
  output logic             o_ref_aux,
  output logic [11:0]      o_main_ratio,
  output logic [11:0]      o_aux_ratio,
  output logic [4:0]       o_main_gain,
  output logic [4:0]       o_aux_gain,
  output logic [2:0]       o_pwrdn,
  output logic             o_int_steer_en,
  output logic             o_lock_steer_out,
  output logic             o_lock_steer_oe
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0]  sclk_sync;
  logic [2:0]  csn_sync;
  logic [2:0]  xtal_sync;
  logic [1:0]  sdat_sync;
  logic [1:0]  lock_sync;
  logic [1:0]  slow_sync;
  logic [1:0]  fast_sync;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        csn_rise;
  logic        xtal_rise;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_sync <= 3'h0;
      csn_sync  <= 3'h7;
      xtal_sync <= 3'h0;
      sdat_sync <= 2'h0;
      lock_sync <= 2'h0;
      slow_sync <= 2'h0;
      fast_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], i_sclk};
      csn_sync  <= {csn_sync[1:0], i_csn};
      xtal_sync <= {xtal_sync[1:0], i_xtal};
      sdat_sync <= {sdat_sync[0], i_sdata};
      lock_sync <= {lock_sync[0], i_main_locked};
      slow_sync <= {slow_sync[0], i_vco_slow};
      fast_sync <= {fast_sync[0], i_vco_fast};
    end
  end

  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  assign csn_rise  = csn_sync[1] & ~csn_sync[2];
  assign xtal_rise = xtal_sync[1] & ~xtal_sync[2];

  // ------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------
  dfd_ser_st_t state_reg;
  logic [15:0] shift_reg;
  logic [4:0]  cnt_reg;
  logic        end_xfer;
  logic        wr_word;
  logic        wr_short;
  logic [3:0]  wr_addr;

  // shift in at rising serial clock
  // keep only the last sixteen bits
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= SER_IDLE;
      shift_reg <= 16'h0000;
      cnt_reg   <= 5'h00;
    end else begin
      case (state_reg)
        SER_IDLE: begin
          if (!csn_sync[1]) begin
            state_reg <= SER_SHIFT;
            cnt_reg   <= 5'h00;
            shift_reg <= 16'h0000;
          end
        end
        SER_SHIFT: begin
          if (csn_rise) begin
            state_reg <= SER_IDLE;
          end else if (sclk_rise) begin
            shift_reg <= {shift_reg[14:0], sdat_sync[1]};
            if (cnt_reg != 5'h1F) begin
              cnt_reg <= cnt_reg + 5'h01;
            end
          end
        end
        default: state_reg <= SER_IDLE;
      endcase
    end
  end

  // commit only at chip select release
  assign end_xfer = (state_reg == SER_SHIFT) && csn_rise;
  assign wr_word  = end_xfer && (cnt_reg >= `DFD_WORD_EDGES);
  assign wr_short = end_xfer && (cnt_reg < `DFD_SHORT_EDGES);
  assign wr_addr  = shift_reg[`DFD_ADDR_HI:`DFD_ADDR_LO];

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [15:0] regs_reg [`DFD_NUM_REGS];

  for (genvar g = 0; g < `DFD_NUM_REGS; g++) begin : g_reg
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        regs_reg[g] <= `DFD_RST_VAL;
      end else if (wr_word && (wr_addr == 4'(g))) begin
        regs_reg[g] <= shift_reg;
      end else if (wr_short && (g == `DFD_NUM_REGS - 1)) begin
        regs_reg[g] <= shift_reg;
      end
    end
  end

  logic     mode_b18;
  logic     main_frac;
  logic     aux_frac;
  logic     lock_mode;
  dfd_mux_t mux_sel;

  assign mode_b18  = regs_reg[`DFD_A_MODE][`DFD_MODE_B18];
  assign main_frac = regs_reg[`DFD_A_MODE][`DFD_MODE_MFRAC];
  assign aux_frac  = regs_reg[`DFD_A_MODE][`DFD_MODE_AFRAC];
  assign lock_mode = regs_reg[`DFD_A_MODE][`DFD_MODE_LOCK];
  assign mux_sel   = dfd_mux_t'(regs_reg[`DFD_A_MODE][`DFD_MODE_MUX_LO +: 2]);

  // ------------------------------------------------------------
  // active divide ratio, latched when the last word of a set lands
  // ------------------------------------------------------------
  logic [8:0]         main_n_act;
  logic [8:0]         aux_n_act;
  logic signed [17:0] main_dvd_act;
  logic signed [17:0] aux_dvd_act;
  logic               commit_main;
  logic               commit_aux;

  assign commit_main = wr_word && ((wr_addr == `DFD_A_MAIN_MSB)
                       || ((wr_addr == `DFD_A_MAIN_N) && !main_frac));
  assign commit_aux  = wr_word && ((wr_addr == `DFD_A_AUX_DVD)
                       || ((wr_addr == `DFD_A_AUX_N) && !aux_frac));

  // lower eight bits used only in 18-bit mode
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      main_n_act   <= 9'h000;
      main_dvd_act <= 18'sh00000;
    end else if (commit_main) begin
      main_n_act <= (wr_addr == `DFD_A_MAIN_N) ? shift_reg[8:0]
                                              : regs_reg[`DFD_A_MAIN_N][8:0];
      if (wr_addr == `DFD_A_MAIN_MSB) begin
        main_dvd_act <= {shift_reg[9:0],
                         mode_b18 ? regs_reg[`DFD_A_MAIN_LSB][7:0] : 8'h00};
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aux_n_act   <= 9'h000;
      aux_dvd_act <= 18'sh00000;
    end else if (commit_aux) begin
      aux_n_act <= (wr_addr == `DFD_A_AUX_N) ? shift_reg[8:0]
                                            : regs_reg[`DFD_A_AUX_N][8:0];
      if (wr_addr == `DFD_A_AUX_DVD) begin
        aux_dvd_act <= {shift_reg[9:0], 8'h00};
      end
    end
  end

  // ------------------------------------------------------------
  // reference dividers
  // ------------------------------------------------------------
  logic [4:0] ref_code [2];
  logic [4:0] ref_cnt_reg [2];
  logic [1:0] ref_tick;

  assign ref_code[0] = regs_reg[`DFD_A_REF_DIV][4:0];
  assign ref_code[1] = regs_reg[`DFD_A_REF_DIV][9:5];

  // divide crystal by code plus one
  for (genvar r = 0; r < 2; r++) begin : g_ref
    assign ref_tick[r] = xtal_rise && (ref_cnt_reg[r] == ref_code[r])
                         && !regs_reg[`DFD_A_PWRDN][r] && !regs_reg[`DFD_A_PWRDN][2];
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        ref_cnt_reg[r] <= 5'h00;
      end else if (xtal_rise) begin
        ref_cnt_reg[r] <= (ref_cnt_reg[r] >= ref_code[r]) ? 5'h00 : ref_cnt_reg[r] + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // fractional units
  // ------------------------------------------------------------
  dfd_frac_if main_if ();
  dfd_frac_if aux_if ();

  assign main_if.tick     = ref_tick[0];
  assign aux_if.tick      = ref_tick[1];
  assign main_if.dividend = 19'(main_dvd_act)
                            + 19'($signed(regs_reg[`DFD_A_MOD_DATA][11:0]));
  assign aux_if.dividend  = 19'(aux_dvd_act);

  dfd_frac_unit u_main_frac (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .frac      (main_if.unit)
  );

  dfd_frac_unit u_aux_frac (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .frac      (aux_if.unit)
  );

  // ------------------------------------------------------------
  // instantaneous ratios
  // ------------------------------------------------------------
  logic [11:0] main_inst;
  logic [11:0] aux_inst;
  logic [11:0] main_x4;
  logic [11:0] main_lo;
  logic [11:0] main_hi;
  logic [11:0] aux_lo;
  logic [11:0] aux_hi;

  assign main_inst = 12'(main_n_act) + `DFD_N_OFFSET
                     + (main_frac ? 12'($signed(main_if.step)) : 12'h000);
  assign aux_inst  = 12'(aux_n_act) + `DFD_N_OFFSET
                     + (aux_frac ? 12'($signed(aux_if.step)) : 12'h000);
  assign main_x4   = {main_inst[9:0], 2'b00};
  assign main_lo   = main_frac ? `DFD_M_FRAC_MIN : `DFD_M_INT_MIN;
  assign main_hi   = main_frac ? `DFD_M_FRAC_MAX : `DFD_M_INT_MAX;
  assign aux_lo    = aux_frac ? `DFD_A_FRAC_MIN : `DFD_A_INT_MIN;
  assign aux_hi    = aux_frac ? `DFD_A_FRAC_MAX : `DFD_A_INT_MAX;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_main_ratio <= `DFD_M_INT_MIN;
      o_aux_ratio  <= `DFD_A_INT_MIN;
      o_ref_main   <= 1'b0;
      o_ref_aux    <= 1'b0;
    end else begin
      o_ref_main <= ref_tick[0];
      o_ref_aux  <= ref_tick[1];
      if (ref_tick[0]) begin
        o_main_ratio <= (main_x4 < main_lo) ? main_lo : (main_x4 > main_hi) ? main_hi : main_x4;
      end
      if (ref_tick[1]) begin
        o_aux_ratio <= (aux_inst < aux_lo) ? aux_lo : (aux_inst > aux_hi) ? aux_hi : aux_inst;
      end
    end
  end

  // ------------------------------------------------------------
  // gains, power down, lock and steering, readback
  // ------------------------------------------------------------
  // five-bit gain codes
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_main_gain <= 5'h00;
      o_aux_gain  <= 5'h00;
      o_pwrdn     <= 3'h0;
    end else begin
      o_main_gain <= regs_reg[`DFD_A_PUMP][4:0];
      o_aux_gain  <= regs_reg[`DFD_A_PUMP][9:5];
      o_pwrdn     <= regs_reg[`DFD_A_PWRDN][2:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_int_steer_en   <= 1'b0;
      o_lock_steer_out <= 1'b0;
      o_lock_steer_oe  <= 1'b0;
    end else if (lock_mode) begin
      o_int_steer_en   <= 1'b1;
      o_lock_steer_out <= 1'b0;
      if (lock_sync[1]) begin
        o_lock_steer_oe <= 1'b0;
      end else if (ref_tick[0]) begin
        o_lock_steer_oe <= ~o_lock_steer_oe;
      end
    end else begin
      o_int_steer_en   <= 1'b0;
      o_lock_steer_out <= slow_sync[1];
      o_lock_steer_oe  <= slow_sync[1] ^ fast_sync[1];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sdo <= 1'b0;
    end else begin
      case (mux_sel)
        MUX_LOOP:     o_sdo <= sclk_fall ? shift_reg[0] : o_sdo;
        MUX_LOCK:     o_sdo <= lock_sync[1];
        MUX_REF_MAIN: o_sdo <= ref_tick[0];
        MUX_REF_AUX:  o_sdo <= ref_tick[1];
        default:      o_sdo <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_ref_wrap;
    @(posedge i_ref_clk) disable iff (!i_resetn) ref_tick[0] |=> ref_cnt_reg[0] == 5'h00;
  endproperty
  a_ref_wrap: assert property (p_ref_wrap) else $error("reference counter did not wrap");

  property p_ten_bit;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (commit_main && wr_addr == `DFD_A_MAIN_MSB && !mode_b18) |=> main_dvd_act[7:0] == 8'h00;
  endproperty
  a_ten_bit: assert property (p_ten_bit) else $error("low dividend bits used in 10-bit mode");

  property p_main_range;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (ref_tick[0] && main_frac) |=> (o_main_ratio >= `DFD_M_FRAC_MIN)
                                     && (o_main_ratio <= `DFD_M_FRAC_MAX);
  endproperty
  a_main_range: assert property (p_main_range) else $error("main ratio out of range");

  property p_mult_four;
    @(posedge i_ref_clk) disable iff (!i_resetn) o_main_ratio[1:0] == 2'b00;
  endproperty
  a_mult_four: assert property (p_mult_four) else $error("main ratio not multiple of four");

  property p_aux_range;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (ref_tick[1] && !aux_frac) |=> (o_aux_ratio >= `DFD_A_INT_MIN)
                                    && (o_aux_ratio <= `DFD_A_INT_MAX);
  endproperty
  a_aux_range: assert property (p_aux_range) else $error("aux ratio out of range");

  property p_gain;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_word && wr_addr == `DFD_A_PUMP |=> ##1 o_main_gain == $past(shift_reg[4:0], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain code not applied");

  property p_locked_release;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (lock_mode && lock_sync[1]) |=> !o_lock_steer_oe && !o_lock_steer_out;
  endproperty
  a_locked_release: assert property (p_locked_release) else $error("pin driven while locked");

  property p_word_write;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (wr_word && wr_addr == `DFD_A_MODE) |=> regs_reg[`DFD_A_MODE] == $past(shift_reg);
  endproperty
  a_word_write: assert property (p_word_write) else $error("register write lost");

  property p_short_load;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_short |=> regs_reg[`DFD_A_MOD_DATA] == $past(shift_reg);
  endproperty
  a_short_load: assert property (p_short_load) else $error("short stream not loaded");

  property p_no_mid_write;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (state_reg == SER_SHIFT && !csn_rise) |=> $stable(regs_reg[`DFD_A_PWRDN]);
  endproperty
  a_no_mid_write: assert property (p_no_mid_write) else $error("write during shifting");

  c_short: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) wr_short);
  c_word: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) wr_word);
  c_lock_pulse: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
                                lock_mode && o_lock_steer_oe);
endmodule

//--- testbench/dfd_mcu_model.sv
// serial master model driving the three-wire port
`timescale 1ns/1ps
module dfd_mcu_model (
  output logic o_sclk,
  output logic o_sdata,
  output logic o_csn
);
  initial begin
    o_sclk  = 1'b0;
    o_sdata = 1'b1;
    o_csn   = 1'b1;
  end
  task automatic shift(input logic [19:0] w, input int n);
    o_csn = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdata = w[i];
      #31.25 o_sclk = 1'b1;
      #62.5 o_sclk = 1'b0;
      #31.25;
    end
  endtask
  task automatic finish();
    o_csn   = 1'b1;
    o_sdata = ~o_sdata;
  endtask
endmodule

//--- testbench/dfd_ctrl_bench.sv
// self-checking bench for the control core
`timescale 1ns/1ps
module dfd_ctrl_bench;
  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic        xtal   = 1'b0;
  logic        locked = 1'b0;
  logic        slow   = 1'b0;
  logic        fast   = 1'b0;
  wire         sclk;
  wire         sdata;
  wire         csn;
  logic        sdo;
  logic        rm;
  logic        ra;
  logic        isen;
  logic        lso;
  logic        lsoe;
  logic        b;
  logic [11:0] mr;
  logic [11:0] ar;
  logic [4:0]  mg;
  logic [4:0]  ag;
  logic [2:0]  pd;
  int          error_cnt  = 0;
  int          num_checks = 0;
  int          n;
  int          s;

  always #2 clk = ~clk;
  always #20 xtal = ~xtal;

  dfd_mcu_model m (.o_sclk(sclk), .o_sdata(sdata), .o_csn(csn));

  dfd_ctrl i_dut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_sclk(sclk), .i_sdata(sdata), .i_csn(csn),
    .i_xtal(xtal), .i_main_locked(locked), .i_vco_slow(slow), .i_vco_fast(fast),
    .o_sdo(sdo), .o_ref_main(rm), .o_ref_aux(ra), .o_main_ratio(mr), .o_aux_ratio(ar),
    .o_main_gain(mg), .o_aux_gain(ag), .o_pwrdn(pd), .o_int_steer_en(isen),
    .o_lock_steer_out(lso), .o_lock_steer_oe(lsoe)
  );

  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [15:0] w);
    m.shift({4'h0, w}, 16);
    m.finish();
    repeat (12) @(negedge clk);
  endtask

  // cycles up to the next reference pulse, 500 if none
  task automatic wait_pulse(input bit aux, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (!(aux ? ra : rm) && k < 500);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check("main_ratio", mr, 12'h080);
    check("aux_ratio", ar, 12'h020);
    slow = 1'b1;
    repeat (6) @(negedge clk);
    check("steer_oe", {11'h000, lsoe}, 12'h001);
    check("steer_out", {11'h000, lso}, 12'h001);
    slow = 1'b0;
    fast = 1'b1;
    repeat (6) @(negedge clk);
    check("steer_oe", {11'h000, lsoe}, 12'h001);
    check("steer_out", {11'h000, lso}, 12'h000);
    fast = 1'b0;
    wr(16'h5003);
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    check("main_period", 12'(n), 12'h028);
    wait_pulse(1'b1, n);
    wait_pulse(1'b1, n);
    check("aux_period", 12'(n), 12'h00A);
    wr(16'h01FF);
    wr(16'h11FF);
    repeat (2) wait_pulse(1'b0, n);
    repeat (2) wait_pulse(1'b1, n);
    check("main_ratio", mr, 12'h87C);
    check("aux_ratio", ar, 12'h21F);
    m.shift(20'h062BF, 16);
    repeat (20) @(negedge clk);
    check("main_gain", {7'h00, mg}, 12'h000);
    m.finish();
    repeat (12) @(negedge clk);
    check("main_gain", {7'h00, mg}, 12'h01F);
    check("aux_gain", {7'h00, ag}, 12'h015);
    check("loopback", {11'h000, sdo}, 12'h001);
    // 14 edges are refused; taken as a word they would set main N to 5
    m.shift(20'h00005, 14);
    m.finish();
    repeat (12) @(negedge clk);
    check("main_gain", {7'h00, mg}, 12'h01F);
    // 12 edges go to modulation data, never to main N
    m.shift(20'h00000, 12);
    m.finish();
    repeat (12) @(negedge clk);
    repeat (2) wait_pulse(1'b0, n);
    check("short_keep", mr, 12'h87C);
    m.shift(20'hF7005, 20);
    m.finish();
    repeat (12) @(negedge clk);
    check("pwrdn", {9'h000, pd}, 12'h005);
    wait_pulse(1'b0, n);
    check("main_ticks_off", 12'(n), 12'h1F4);
    wr(16'h7000);
    check("loopback", {11'h000, sdo}, 12'h000);
    wr(16'h8008);
    check("int_steer", {11'h000, isen}, 12'h001);
    locked = 1'b1;
    repeat (8) @(negedge clk);
    check("lock_oe", {11'h000, lsoe}, 12'h000);
    locked = 1'b0;
    wait_pulse(1'b0, n);
    repeat (2) @(negedge clk);
    b = lsoe;
    wait_pulse(1'b0, n);
    repeat (2) @(negedge clk);
    check("lock_toggle", {11'h000, lsoe}, {11'h000, ~b});
    check("lock_out", {11'h000, lso}, 12'h000);
    // steering mode, main fractional, lock status on the mux output
    wr(16'h8012);
    locked = 1'b1;
    repeat (6) @(negedge clk);
    check("mux_lock", {11'h000, sdo}, 12'h001);
    check("int_steer", {11'h000, isen}, 12'h000);
    locked = 1'b0;
    // N of 6 plus a quarter: exactly one step up in any four ticks
    wr(16'h0006);
    wr(16'h2100);
    wait_pulse(1'b0, n);
    s = 0;
    repeat (4) begin
      wait_pulse(1'b0, n);
      s += mr;
    end
    check("main_frac_sum", 12'(s), 12'h264);
    end_sim();
  end

  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule
